// *** include/pwt_pkg.sv ***
// constants, types and register map of the pwm timer slice
// assumes a single 50 MHz clock shared by core, bus and converter side
package pwt_pkg;
  // clock and event spacing
  localparam int CLK_NS = 20;
  localparam int GAP_CORE_N = 6;
  localparam int GAP_BUS_N = 4;
  localparam int GAP_NS = GAP_CORE_N * CLK_NS + GAP_BUS_N * CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SWSTART = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0C;
  localparam logic [7:0] OFF_PCOUNT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_IOCTL = 8'h1C;
  localparam logic [7:0] OFF_IOBUF = 8'h20;
  localparam logic [7:0] OFF_STOPCFG = 8'h24;
  localparam logic [7:0] OFF_CMP = 8'h28;
  localparam logic [7:0] OFF_ADCSEL = 8'h40;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_TRI = 1;
  localparam int PC_EN = 8;
  localparam int BUF_EN = 8;
  localparam int SC_PIN_EN = 0;
  localparam int SC_SHORT_EN = 1;
  localparam int SC_CANCEL = 2;
  localparam int SC_PIN_CLR = 4;
  localparam int SC_SHORT_CLR = 5;
  localparam int ST_OVF = 0;
  localparam int ST_TROUGH = 1;
  localparam int ST_PCF = 2;
  localparam int ST_STOP = 3;
  localparam int NSTAT = 4;
  localparam int NADC = 9;
  // reset values
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] PCOUNT_RST = 8'h00;
  localparam logic [1:0] IOFN_RST = 2'h0;
  // adc trigger sources
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_OVF = 2'h1;
  localparam logic [1:0] SRC_TROUGH = 2'h2;
  localparam logic [1:0] SRC_CMP = 2'h3;
  // counting direction
  typedef enum logic {PWT_UP = 1'b0, PWT_DOWN = 1'b1} pwt_dir_t;
endpackage

// *** design/pwt_core.sv ***
// pwm timer slice: counter, period count, io field, output stop, adc trig
// assumes an apb master on sys_clk; detect and event pins are asynchronous
//
// Overview of operation
// - detection flags keep stop request asserted regardless
// - stop request is OR of detection signals
// - period stop versus start: finish, keep counting
// - io field write beats buffer transfer
// - io field read returns pre-update value
// - interrupt is the registered status and mask level, repeats not spaced
// - nine adc trigger selects bypass event link
// - same adc trigger repeats spaced by gap
// - incoming event repeats not spaced; each synced rising edge starts the counter
// - different selects are not spaced against each other
`timescale 1ns/1ps
module pwt_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pinDetect,
  input wire logic shortDetect,
  input wire logic extEvent,
  output logic pwmOut,
  output logic stopReq,
  output logic irq,
  output logic [8:0] adcTrig
);
  localparam int GAP = pwt_pkg::GAP_CYC;
  localparam int NSTAT = pwt_pkg::NSTAT; // status and mask width
  localparam int NADC = pwt_pkg::NADC; // direct adc trigger channels

  // address match, used by every write decode below
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // pin synchronisers, first stage read only by second
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic extPrev_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      extPrev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {extEvent, shortDetect, pinDetect};
      sync2_q <= sync1_q;
      extPrev_q <= sync2_q[2];
    end
  end
  wire pinS = sync2_q[0];
  wire shortS = sync2_q[1];
  wire extRise = sync2_q[2] & ~extPrev_q;

  // bus strobes: setup answered with pready in the following access cycle
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rdStat = acc & ~pwrite & hit(paddr, pwt_pkg::OFF_STATUS);

  // register state
  logic startBit_q, startBit_d;   // count start
  logic tri_q, tri_d;             // triangle mode
  logic [15:0] period_q, period_d;
  logic [15:0] cmp_q, cmp_d;
  logic [15:0] cnt_q, cnt_d;      // running counter
  pwt_pkg::pwt_dir_t dir_q, dir_d;
  logic [7:0] pcTarget_q, pcTarget_d;
  logic [7:0] pcCnt_q, pcCnt_d;   // periods seen so far
  logic pcEn_q, pcEn_d;
  logic [NSTAT-1:0] stat_q, stat_d;
  logic [NSTAT-1:0] mask_q, mask_d;
  logic [1:0] ioFn_q, ioFn_d;     // io pin function field
  logic [1:0] ioBuf_q, ioBuf_d;
  logic bufEn_q, bufEn_d;
  logic [2:0] stopCfg_q, stopCfg_d;
  logic pinFlag_q, pinFlag_d;
  logic shortFlag_q, shortFlag_d;
  logic [1:0] adcSel_q [NADC];
  logic ovf, trough, cmpHit, pcDone, swStart, bufXfer, ioWr, rawDet;

  // counter, period count, io field, flags and status
  always_comb
  begin
    startBit_d = startBit_q;
    tri_d = tri_q;
    period_d = period_q;
    cmp_d = cmp_q;
    cnt_d = cnt_q;
    dir_d = dir_q;
    pcTarget_d = pcTarget_q;
    pcCnt_d = pcCnt_q;
    pcEn_d = pcEn_q;
    stat_d = stat_q;
    mask_d = mask_q;
    ioFn_d = ioFn_q;
    ioBuf_d = ioBuf_q;
    bufEn_d = bufEn_q;
    stopCfg_d = stopCfg_q;
    pinFlag_d = pinFlag_q;
    shortFlag_d = shortFlag_q;
    ovf = 1'b0;
    trough = 1'b0;
    // counting, direction held as a two-state machine
    if (startBit_q)
    begin
      case (dir_q)
        pwt_pkg::PWT_UP:
        begin
          if (cnt_q >= period_q)
          begin
            ovf = 1'b1;
            if (tri_q)
            begin
              dir_d = pwt_pkg::PWT_DOWN;
              cnt_d = cnt_q - 16'h0001;
            end
            else
              cnt_d = 16'h0000;
          end
          else
            cnt_d = cnt_q + 16'h0001;
        end
        pwt_pkg::PWT_DOWN:
        begin
          if (cnt_q == 16'h0000)
          begin
            trough = 1'b1;
            dir_d = pwt_pkg::PWT_UP;
            cnt_d = 16'h0001;
          end
          else
            cnt_d = cnt_q - 16'h0001;
        end
        default: dir_d = pwt_pkg::PWT_UP;
      endcase
    end
    cmpHit = startBit_q & (cnt_q == cmp_q);
    // period count: one period per overflow
    pcDone = 1'b0;
    if (pcEn_q && ovf)
    begin
      if (pcCnt_q + 8'h01 >= pcTarget_q)
        pcDone = 1'b1;
      else
        pcCnt_d = pcCnt_q + 8'h01;
    end
    // a start through either register counts as a software start
    swStart = wr & ((hit(paddr, pwt_pkg::OFF_SWSTART) & pwdata[0])
      | (hit(paddr, pwt_pkg::OFF_CTRL) & pwdata[pwt_pkg::CTRL_START]));
    // control writes first, conflicts resolved afterwards
    if (wr && hit(paddr, pwt_pkg::OFF_CTRL))
    begin
      startBit_d = pwdata[pwt_pkg::CTRL_START];
      tri_d = pwdata[pwt_pkg::CTRL_TRI];
    end
    if (swStart)
      startBit_d = 1'b1;
    if (wr && hit(paddr, pwt_pkg::OFF_PERIOD))
      period_d = pwdata[15:0];
    if (wr && hit(paddr, pwt_pkg::OFF_CMP))
      cmp_d = pwdata[15:0];
    if (wr && hit(paddr, pwt_pkg::OFF_PCOUNT))
    begin
      pcTarget_d = pwdata[7:0];
      pcEn_d = pwdata[pwt_pkg::PC_EN];
      pcCnt_d = 8'h00;
    end
    if (pcDone)
    begin
      // finish period count; start write, if any, keeps counter going
      pcEn_d = 1'b0;
      pcCnt_d = 8'h00;
      if (!swStart)
        startBit_d = 1'b0;
    end
    if (wr && hit(paddr, pwt_pkg::OFF_MASK))
      mask_d = pwdata[NSTAT-1:0];
    // io field: buffer transfer at overflow, software write wins
    ioWr = wr & hit(paddr, pwt_pkg::OFF_IOCTL);
    bufXfer = bufEn_q & ovf;
    if (bufXfer)
      ioFn_d = ioBuf_q;
    if (ioWr)
      ioFn_d = pwdata[1:0];
    if (wr && hit(paddr, pwt_pkg::OFF_IOBUF))
    begin
      ioBuf_d = pwdata[1:0];
      bufEn_d = pwdata[pwt_pkg::BUF_EN];
    end
    // detection flags: software clear, detection set wins
    if (wr && hit(paddr, pwt_pkg::OFF_STOPCFG))
    begin
      stopCfg_d = pwdata[2:0];
      if (pwdata[pwt_pkg::SC_PIN_CLR])
        pinFlag_d = 1'b0;
      if (pwdata[pwt_pkg::SC_SHORT_CLR])
        shortFlag_d = 1'b0;
    end
    if (pinS && stopCfg_q[pwt_pkg::SC_PIN_EN])
      pinFlag_d = 1'b1;
    if (shortS && stopCfg_q[pwt_pkg::SC_SHORT_EN])
      shortFlag_d = 1'b1;
    // sticky status: read clears, a same-cycle event wins
    // clear only what the read reported: an event after setup survives
    if (rdStat)
      stat_d = stat_q & ~prdata[NSTAT-1:0];
    if (ovf)
      stat_d[pwt_pkg::ST_OVF] = 1'b1;
    if (trough)
      stat_d[pwt_pkg::ST_TROUGH] = 1'b1;
    if (pcDone)
      stat_d[pwt_pkg::ST_PCF] = 1'b1;
    if (rawDet && !stopReq)
      stat_d[pwt_pkg::ST_STOP] = 1'b1;
    // external event starts counting, one per synced edge
    if (extRise)
      startBit_d = 1'b1;
  end

  // raw detection path; the cancel bit only silences this path
  assign rawDet = pinFlag_q | shortFlag_q | (~stopCfg_q[pwt_pkg::SC_CANCEL]
    & ((pinS & stopCfg_q[pwt_pkg::SC_PIN_EN])
    | (shortS & stopCfg_q[pwt_pkg::SC_SHORT_EN])));

  // register the core state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startBit_q <= 1'b0;
      tri_q <= 1'b0;
      period_q <= pwt_pkg::PERIOD_RST;
      cmp_q <= pwt_pkg::CMP_RST;
      cnt_q <= 16'h0000;
      dir_q <= pwt_pkg::PWT_UP;
      pcTarget_q <= pwt_pkg::PCOUNT_RST;
      pcCnt_q <= 8'h00;
      pcEn_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      ioFn_q <= pwt_pkg::IOFN_RST;
      ioBuf_q <= pwt_pkg::IOFN_RST;
      bufEn_q <= 1'b0;
      stopCfg_q <= 3'h0;
      pinFlag_q <= 1'b0;
      shortFlag_q <= 1'b0;
      stopReq <= 1'b0;
      irq <= 1'b0;
      pwmOut <= 1'b0;
    end
    else
    begin
      startBit_q <= startBit_d;
      tri_q <= tri_d;
      period_q <= period_d;
      cmp_q <= cmp_d;
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      pcTarget_q <= pcTarget_d;
      pcCnt_q <= pcCnt_d;
      pcEn_q <= pcEn_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ioFn_q <= ioFn_d;
      ioBuf_q <= ioBuf_d;
      bufEn_q <= bufEn_d;
      stopCfg_q <= stopCfg_d;
      pinFlag_q <= pinFlag_d;
      shortFlag_q <= shortFlag_d;
      stopReq <= rawDet;
      irq <= |(stat_q & mask_q);
      // stop forces the pin low; field picks the waveform
      pwmOut <= ~rawDet & (ioFn_q[1] ? ((cnt_q < cmp_q) ^ ioFn_q[0])
        : ioFn_q[0]);
    end
  end

  // adc trigger channels, each spaced on its own
  genvar gi;
  generate
    for (gi = 0; gi < NADC; gi++)
    begin : g_adc
      logic pend_q, pend_d;
      logic [7:0] gap_q, gap_d;
      logic src;
      always_comb
      begin
        case (adcSel_q[gi])
          pwt_pkg::SRC_OVF: src = ovf;
          pwt_pkg::SRC_TROUGH: src = trough;
          pwt_pkg::SRC_CMP: src = cmpHit;
          default: src = 1'b0;
        endcase
        pend_d = pend_q | src;
        gap_d = (gap_q != 8'h00) ? gap_q - 8'h01 : 8'h00;
        if (pend_q && gap_q == 8'h00)
        begin
          pend_d = src;
          gap_d = 8'(GAP - 1);
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pend_q <= 1'b0;
          gap_q <= 8'h00;
          adcTrig[gi] <= 1'b0;
          adcSel_q[gi] <= pwt_pkg::SRC_NONE;
        end
        else
        begin
          pend_q <= pend_d;
          gap_q <= gap_d;
          adcTrig[gi] <= pend_q & (gap_q == 8'h00);
          if (wr && hit(paddr, pwt_pkg::OFF_ADCSEL + 8'(gi * 4)))
            adcSel_q[gi] <= pwdata[1:0];
        end
      end
    end
  endgenerate

  // apb slave: read data caught at setup, so a same-edge update reads old
  logic [31:0] rd;
  logic mapped;
  always_comb
  begin
    rd = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr >= pwt_pkg::OFF_ADCSEL
      && paddr < pwt_pkg::OFF_ADCSEL + 8'(NADC * 4) && paddr[1:0] == 2'h0)
      rd[1:0] = adcSel_q[4'((paddr - pwt_pkg::OFF_ADCSEL) >> 2)];
    else
      case (paddr)
        pwt_pkg::OFF_CTRL: rd[1:0] = {tri_q, startBit_q};
        pwt_pkg::OFF_SWSTART: rd = 32'h0000_0000;
        pwt_pkg::OFF_PERIOD: rd[15:0] = period_q;
        pwt_pkg::OFF_CNT: rd[15:0] = cnt_q;
        pwt_pkg::OFF_PCOUNT: rd[8:0] = {pcEn_q, pcTarget_q};
        pwt_pkg::OFF_STATUS: rd[NSTAT-1:0] = stat_q;
        pwt_pkg::OFF_MASK: rd[NSTAT-1:0] = mask_q;
        pwt_pkg::OFF_IOCTL: rd[1:0] = ioFn_q;
        pwt_pkg::OFF_IOBUF: rd[8:0] = {bufEn_q, 6'h00, ioBuf_q};
        pwt_pkg::OFF_STOPCFG:
          rd[5:0] = {shortFlag_q, pinFlag_q, 1'b0, stopCfg_q};
        pwt_pkg::OFF_CMP: rd[15:0] = cmp_q;
        default: mapped = 1'b0;
      endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd;
    end
  end

  // checks
  logic [7:0] since0_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      since0_q <= 8'hFF;
    else if (adcTrig[0])
      since0_q <= 8'h01;
    else if (since0_q != 8'hFF)
      since0_q <= since0_q + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_stop_flag_hold: assert property ((pinFlag_q || shortFlag_q) |=> stopReq)
    else $error("stop request dropped while flag set");
  a_stop_or_src: assert property (stopReq |-> $past(pinFlag_q
    || shortFlag_q || pinS || shortS))
    else $error("stop request without a detection");
  a_pc_conflict: assert property (pcDone && swStart |=> startBit_q
    && stat_q[pwt_pkg::ST_PCF] && !pcEn_q)
    else $error("period stop beat software start");
  a_io_write_wins: assert property (ioWr && bufXfer
    |=> ioFn_q == $past(pwdata[1:0]))
    else $error("buffer transfer beat io write");
  a_io_read_old: assert property (setup && !pwrite
    && hit(paddr, pwt_pkg::OFF_IOCTL) |=> prdata[1:0] == $past(ioFn_q))
    else $error("io read did not return old value");
  a_adc_gap: assert property (adcTrig[0] |-> since0_q >= 8'(GAP))
    else $error("adc trigger repeated too soon");
  a_irq_level: assert property (|(stat_q & mask_q) |=> irq)
    else $error("interrupt not raised");
  a_ext_start: assert property (extRise |=> startBit_q)
    else $error("event did not start counter");
  a_apb_ready: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  c_pc_conflict: cover property (pcDone && swStart);
  c_io_conflict: cover property (ioWr && bufXfer);
  c_adc_trig: cover property (adcTrig[0] ##[1:40] adcTrig[0]);
endmodule

// *** dv/pwt_far_model.sv ***
// far side of the timer slice: detect pins, event link, adc trigger sink
// assumes the bench calls its tasks right after a rising sys_clk edge
`timescale 1ns/1ps
module pwt_far_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [8:0] adcTrig,
  output logic pinDetect,
  output logic shortDetect,
  output logic extEvent,
  output logic [8:0] seenTrig,
  output logic gapViol
);
  int cyc; // free cycle count
  int lastHit [pwt_pkg::NADC]; // cycle of last pulse per channel

  initial
  begin
    pinDetect = 1'b0;
    shortDetect = 1'b0;
    extEvent = 1'b0;
  end

  // hold one detect level for n cycles; longer than the 2-stage synchroniser
  task automatic detect(input logic which, input int n);
    if (which)
      shortDetect <= 1'b1;
    else
      pinDetect <= 1'b1;
    repeat (n) @(posedge sys_clk);
    shortDetect <= 1'b0;
    pinDetect <= 1'b0;
  endtask

  // one event, then a quiet gap so repeats never come too close
  task automatic evt();
    extEvent <= 1'b1;
    repeat (4) @(posedge sys_clk);
    extEvent <= 1'b0;
    repeat (pwt_pkg::GAP_CYC) @(posedge sys_clk);
  endtask

  // adc side: direct triggers taken, a too-close repeat sets gapViol
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc <= 0;
      seenTrig <= 9'h000;
      gapViol <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 1;
      for (int i = 0; i < pwt_pkg::NADC; i++)
        if (adcTrig[i] === 1'b1)
        begin
          seenTrig[i] <= 1'b1;
          lastHit[i] <= cyc;
          if (seenTrig[i] && cyc - lastHit[i] < pwt_pkg::GAP_CYC)
            gapViol <= 1'b1;
        end
    end
  end
endmodule

// *** dv/pwm_timer_event_and_stop_logic_bench.sv ***
// bench for the timer slice: apb master, read-note queue, far model
// assumes pwt_pkg, pwt_core and pwt_far_model are compiled first
`timescale 1ns/1ps
module pwm_timer_event_and_stop_logic_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pinDetect;
  logic shortDetect;
  logic extEvent;
  logic pwmOut;
  logic stopReq;
  logic irq;
  logic [8:0] adcTrig;
  logic [8:0] seenTrig;
  logic gapViol;
  logic [32:0] expQ[$]; // notes: {slverr, data} per read
  logic [32:0] note;
  logic [31:0] v;
  int err_total = 0;
  int checks = 0;

  always #10 sys_clk = ~sys_clk;

  pwt_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinDetect(pinDetect), .shortDetect(shortDetect), .extEvent(extEvent),
    .pwmOut(pwmOut), .stopReq(stopReq), .irq(irq), .adcTrig(adcTrig));

  pwt_far_model i_far (.sys_clk(sys_clk), .rst_n(rst_n), .adcTrig(adcTrig),
    .pinDetect(pinDetect), .shortDetect(shortDetect), .extEvent(extEvent),
    .seenTrig(seenTrig), .gapViol(gapViol));

  task automatic end_sim();
    $display("counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready under a bound, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        err_total++;
        end_sim();
      end
      @(posedge sys_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // read with a note of what must come back
  task automatic rd(input logic [7:0] a, input logic e,
    input logic [31:0] d);
    expQ.push_back({e, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // read watcher: completed read against the oldest note
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
    begin
      note = expQ.pop_front();
      check("pslverr", {31'h0000_0000, pslverr}, {31'h0000_0000, note[32]});
      check("prdata", prdata, note[31:0]);
    end
  end

  initial
  begin
    v = $urandom(32'hc6e9a6e6);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1; // single fixed clock source
    @(posedge sys_clk);
    // reset values, unmapped place refused
    rd(pwt_pkg::OFF_PERIOD, 1'b0, {16'h0000, pwt_pkg::PERIOD_RST});
    rd(pwt_pkg::OFF_CTRL, 1'b0, 32'h0000_0000);
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 1'b1, 32'h0000_0000);
    $display("test regmap done");
    // io field: random functions while stopped; cnt equals cmp here
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      apb(1'b1, pwt_pkg::OFF_IOCTL, v);
      rd(pwt_pkg::OFF_IOCTL, 1'b0, {30'h0000_0000, v[1:0]});
      check("pwmOut", {31'h0, pwmOut}, {31'h0, v[0]});
    end
    $display("test iofield done");
    // stop request held by flags despite cancel, irq on stop event
    apb(1'b1, pwt_pkg::OFF_MASK, 32'h0000_0008);
    apb(1'b1, pwt_pkg::OFF_STOPCFG, 32'h0000_0003);
    i_far.detect(1'b0, 5);
    apb(1'b1, pwt_pkg::OFF_STOPCFG, 32'h0000_0007);
    cyc(3);
    check("stopReq", {31'h0, stopReq}, 32'h0000_0001);
    check("pwmOut", {31'h0, pwmOut}, 32'h0000_0000);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    rd(pwt_pkg::OFF_STOPCFG, 1'b0, 32'h0000_0017);
    i_far.detect(1'b1, 5);
    cyc(2);
    rd(pwt_pkg::OFF_STOPCFG, 1'b0, 32'h0000_0037);
    apb(1'b1, pwt_pkg::OFF_STOPCFG, 32'h0000_0033);
    cyc(3);
    check("stopReq", {31'h0, stopReq}, 32'h0000_0000);
    rd(pwt_pkg::OFF_STATUS, 1'b0, 32'h0000_0008);
    cyc(3);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    $display("test stop done");
    // every adc source: channel 0 ovf, 1 trough, 2 cmp, 3 none, ...
    for (int i = 0; i < pwt_pkg::NADC; i++)
      apb(1'b1, pwt_pkg::OFF_ADCSEL + 8'(4 * i), 32'((i + 1) % 4));
    apb(1'b1, pwt_pkg::OFF_PERIOD, 32'h0000_0003);
    // triangle first, so the saw run leaves the counter counting up
    apb(1'b1, pwt_pkg::OFF_CTRL, 32'h0000_0003);
    cyc(60);
    check("trig trough", {31'h0, seenTrig[1]}, 32'h0000_0001);
    apb(1'b1, pwt_pkg::OFF_CTRL, 32'h0000_0001);
    cyc(20);
    // io writes every 3 cycles meet the 4-cycle overflow transfer
    apb(1'b1, pwt_pkg::OFF_IOBUF, 32'h0000_0102);
    for (int i = 0; i < 4; i++)
      apb(1'b1, pwt_pkg::OFF_IOCTL, 32'h0000_0001);
    apb(1'b1, pwt_pkg::OFF_IOBUF, 32'h0000_0000);
    cyc(100);
    check("trig none", {31'h0, seenTrig[3]}, 32'h0000_0000);
    check("trig ovf", {31'h0, seenTrig[0]}, 32'h0000_0001);
    check("trig cmp", {31'h0, seenTrig[2]}, 32'h0000_0001);
    check("trig gap", {31'h0, gapViol}, 32'h0000_0000);
    $display("test adc done");
    // event link start, then period count finishing the run
    apb(1'b1, pwt_pkg::OFF_CTRL, 32'h0000_0000);
    cyc(2);
    rd(pwt_pkg::OFF_STATUS, 1'b0, 32'h0000_0003); // ovf and trough
    i_far.evt();
    rd(pwt_pkg::OFF_CTRL, 1'b0, 32'h0000_0001);
    apb(1'b1, pwt_pkg::OFF_CTRL, 32'h0000_0000);
    rd(pwt_pkg::OFF_STATUS, 1'b0, 32'h0000_0001);
    apb(1'b1, pwt_pkg::OFF_PCOUNT, 32'h0000_0101);
    apb(1'b1, pwt_pkg::OFF_SWSTART, 32'h0000_0001);
    cyc(30);
    rd(pwt_pkg::OFF_CTRL, 1'b0, 32'h0000_0000);
    rd(pwt_pkg::OFF_STATUS, 1'b0, 32'h0000_0005);
    // counter left at 0: start lands 4 edges before the finishing ovf,
    // so the software start write lands on that very edge
    apb(1'b1, pwt_pkg::OFF_PCOUNT, 32'h0000_0101);
    apb(1'b1, pwt_pkg::OFF_CTRL, 32'h0000_0001);
    cyc(1);
    apb(1'b1, pwt_pkg::OFF_SWSTART, 32'h0000_0001);
    cyc(4);
    rd(pwt_pkg::OFF_CTRL, 1'b0, 32'h0000_0001);
    rd(pwt_pkg::OFF_PCOUNT, 1'b0, 32'h0000_0001);
    rd(pwt_pkg::OFF_STATUS, 1'b0, 32'h0000_0005);
    apb(1'b1, pwt_pkg::OFF_CTRL, 32'h0000_0000);
    $display("test events done");
    end_sim();
  end
endmodule
